/* File: verilog/dic_pkg.sv */
`default_nettype none
package dic_pkg;
    localparam int unsigned NUM_STD       = 2;
    localparam int unsigned NUM_IN        = 14;
    localparam int unsigned GRP_SIZE      = 4;
    localparam int unsigned GRP_W         = 2;
    localparam int unsigned AW            = 8;
    localparam int unsigned DW            = 32;
    localparam int unsigned DEB_W         = 7;
    localparam int unsigned TICK_CW       = 16;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_NS       = 1_000_000;
    localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    localparam logic [DEB_W-1:0] DEB_MIN = 7'h01;
    localparam logic [DEB_W-1:0] DEB_MAX = 7'h64;
    localparam logic [DEB_W-1:0] DEB_RST = 7'h0A;

    localparam logic [AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [AW-1:0] REG_INPOL  = 8'h04;
    localparam logic [AW-1:0] REG_MODE   = 8'h08;
    localparam logic [AW-1:0] REG_PPOL   = 8'h0C;
    localparam logic [AW-1:0] REG_STATE  = 8'h10;
    localparam logic [AW-1:0] REG_EVSTAT = 8'h14;
    localparam logic [AW-1:0] REG_EVMASK = 8'h18;

    localparam int unsigned CTRL_DEB_LSB  = 0;
    localparam int unsigned CTRL_GRP_LSB  = 8;
    localparam int unsigned CTRL_SYNC_BIT = 12;
    localparam int unsigned EV_CHG_LSB    = 0;
    localparam int unsigned EV_PLS_LSB    = 16;

    localparam logic [NUM_IN-1:0] NUM_IN_ZERO = 14'h0000;

    // out-of-range writes saturate rather than being refused
    function automatic logic [DEB_W-1:0] clampDeb(input logic [DW-1:0] v);
        if (v < DW'(DEB_MIN)) return DEB_MIN;
        if (v > DW'(DEB_MAX)) return DEB_MAX;
        return v[DEB_W-1:0];
    endfunction

    function automatic logic chanOn(input int unsigned idx, input logic [GRP_W-1:0] grp);
        return idx < (NUM_STD + GRP_SIZE * int'(grp));
    endfunction
endpackage
`default_nettype wire

/* File: verilog/dic_tick.sv */
`default_nettype none
module dic_tick #(
    parameter int unsigned Cycles = dic_pkg::TICK_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    output logic      tick
);
    import dic_pkg::*;

    localparam logic [TICK_CW-1:0] LAST = TICK_CW'(Cycles - 1);

    logic [TICK_CW-1:0] cnt_q, cnt_d;
    logic               tick_q, tick_d;

    always_comb begin
        tick_d = (cnt_q == LAST);
        cnt_d  = tick_d ? '0 : cnt_q + TICK_CW'(1);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule
`default_nettype wire

/* File: verilog/dic_channel.sv */
`default_nettype none
module dic_channel (
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     enable,
    input  wire logic                     tick,
    input  wire logic                     rawIn,
    input  wire logic [dic_pkg::DEB_W-1:0] debounceMs,
    input  wire logic                     inPol,
    input  wire logic                     transMode,
    input  wire logic                     pulsePol,
    output logic                          levelOut,
    output logic                          changeOut,
    output logic                          eventOut
);
    import dic_pkg::*;

    logic             stable_q, stable_d;
    logic [DEB_W-1:0] cnt_q, cnt_d;
    logic             chg_q, chg_d;
    logic             evt_q, evt_d;

    // count starts over whenever the raw level matches the accepted one
    always_comb begin
        stable_d = stable_q;
        cnt_d    = cnt_q;
        chg_d    = 1'b0;
        evt_d    = 1'b0;
        if (!enable) begin
            stable_d = 1'b0;
            cnt_d    = '0;
        end else if (rawIn == stable_q) begin
            cnt_d = '0;
        end else if (tick) begin
            if (cnt_q + DEB_W'(1) >= debounceMs) begin
                stable_d = rawIn;
                cnt_d    = '0;
                chg_d    = 1'b1;
                evt_d    = transMode | (rawIn ^ pulsePol);
            end else begin
                cnt_d = cnt_q + DEB_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_q <= 1'b0;
            cnt_q    <= '0;
            chg_q    <= 1'b0;
            evt_q    <= 1'b0;
        end else begin
            stable_q <= stable_d;
            cnt_q    <= cnt_d;
            chg_q    <= chg_d;
            evt_q    <= evt_d;
        end
    end

    assign levelOut  = stable_q ^ inPol;
    assign changeOut = chg_q;
    assign eventOut  = evt_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_SINGLE_EDGE: assert property (
        eventOut && !$past(transMode) |-> stable_q == !$past(pulsePol))
        else $error("single-edge event on wrong edge");

    AST_TRANS_BOTH: assert property (
        changeOut && $past(transMode) |-> eventOut)
        else $error("transition mode missed an edge");
endmodule
`default_nettype wire

/* File: verilog/dic_top.sv */
// Notes on behaviour
// - normal input polarity: closed contact reads closed
// - inverting input polarity: open contact reads closed
// - single-edge mode: one event per pulse
// - transition mode: event on both edges
// - normal pulse polarity: closing edge counts
// - inverting pulse polarity: opening edge counts
// - transition mode ignores pulse polarity
// - new level accepted after 1-100 ms stable
// - one debounce time shared by all inputs
// - two inputs plus optional 4/8/12 more
// - each state change pulses setpoint trigger
// - each pulse event increments linked counter
// - external sync: first input pulse starts demand
`default_nettype none
module dic_top #(
    parameter int unsigned TickCycles = dic_pkg::TICK_CYCLES
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic [dic_pkg::NUM_IN-1:0] diRaw,
    input  wire logic [dic_pkg::AW-1:0]     regAddr,
    input  wire logic [dic_pkg::DW-1:0]     regWrData,
    input  wire logic                       regWrStb,
    input  wire logic                       regRdStb,
    output logic      [dic_pkg::DW-1:0]     regRdData,
    output logic      [dic_pkg::NUM_IN-1:0] inState,
    output logic      [dic_pkg::NUM_IN-1:0] stateChange,
    output logic      [dic_pkg::NUM_IN-1:0] pulseEvent,
    output logic                            demandSync,
    output logic                            irq
);
    import dic_pkg::*;

    logic [DEB_W-1:0]  deb_q, deb_d;
    logic [GRP_W-1:0]  grp_q, grp_d;
    logic              sync_q, sync_d;
    logic [NUM_IN-1:0] inPol_q, inPol_d;
    logic [NUM_IN-1:0] mode_q, mode_d;
    logic [NUM_IN-1:0] pPol_q, pPol_d;
    logic [DW-1:0]     evStat_q, evStat_d;
    logic [DW-1:0]     evMask_q, evMask_d;
    logic [DW-1:0]     rdData_q, rdData_d;
    logic              dsync_q, dsync_d;

    logic              tick;
    logic [NUM_IN-1:0] chanEn;
    logic [DW-1:0]     evSet;
    logic [DW-1:0]     evClr;
    logic [DW-1:0]     evValid;

    dic_tick #(
        .Cycles (TickCycles)
    ) u_tick (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick     (tick)
    );

    for (genvar i = 0; i < NUM_IN; i++) begin : g_chan
        // optional group size decides which channels run
        assign chanEn[i] = chanOn(i, grp_q);

        dic_channel u_chan (
            .core_clk   (core_clk),
            .rst_n      (rst_n),
            .enable     (chanEn[i]),
            .tick       (tick),
            .rawIn      (diRaw[i]),
            .debounceMs (deb_q),
            .inPol      (inPol_q[i]),
            .transMode  (mode_q[i]),
            .pulsePol   (pPol_q[i]),
            .levelOut   (inState[i]),
            .changeOut  (stateChange[i]),
            .eventOut   (pulseEvent[i])
        );
    end

    assign evValid = {{(DW - EV_PLS_LSB - NUM_IN){1'b0}}, {NUM_IN{1'b1}},
                      {(EV_PLS_LSB - NUM_IN){1'b0}}, {NUM_IN{1'b1}}};

    assign evSet = {{(DW - EV_PLS_LSB - NUM_IN){1'b0}}, pulseEvent,
                    {(EV_PLS_LSB - NUM_IN){1'b0}}, stateChange};

    assign evClr = (regWrStb && regAddr == REG_EVSTAT) ? regWrData : '0;

    // configuration registers
    always_comb begin
        deb_d    = deb_q;
        grp_d    = grp_q;
        sync_d   = sync_q;
        inPol_d  = inPol_q;
        mode_d   = mode_q;
        pPol_d   = pPol_q;
        evMask_d = evMask_q;
        if (regWrStb) begin
            unique case (regAddr)
                REG_CTRL: begin
                    // one field for every input: no per-input copy exists
                    deb_d  = clampDeb(DW'(regWrData[CTRL_DEB_LSB +: DEB_W]));
                    grp_d  = regWrData[CTRL_GRP_LSB +: GRP_W];
                    sync_d = regWrData[CTRL_SYNC_BIT];
                end
                REG_INPOL: begin
                    inPol_d = regWrData[NUM_IN-1:0];
                end
                REG_MODE: begin
                    mode_d = regWrData[NUM_IN-1:0];
                end
                REG_PPOL: begin
                    pPol_d = regWrData[NUM_IN-1:0];
                end
                REG_EVMASK: begin
                    evMask_d = regWrData & evValid;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            deb_q    <= DEB_RST;
            grp_q    <= '0;
            sync_q   <= 1'b0;
            inPol_q  <= NUM_IN_ZERO;
            mode_q   <= NUM_IN_ZERO;
            pPol_q   <= NUM_IN_ZERO;
            evMask_q <= '0;
        end else begin
            deb_q    <= deb_d;
            grp_q    <= grp_d;
            sync_q   <= sync_d;
            inPol_q  <= inPol_d;
            mode_q   <= mode_d;
            pPol_q   <= pPol_d;
            evMask_q <= evMask_d;
        end
    end

    // sticky events: a set in the clearing cycle survives
    always_comb begin
        evStat_d = ((evStat_q & ~evClr) | evSet) & evValid;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evStat_q <= '0;
        end else begin
            evStat_q <= evStat_d;
        end
    end

    assign irq = |(evStat_q & evMask_q);

    // demand sync follows the first input's configured pulse edge
    always_comb begin
        dsync_d = sync_q & pulseEvent[0];
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dsync_q <= 1'b0;
        end else begin
            dsync_q <= dsync_d;
        end
    end

    assign demandSync = dsync_q;

    // read port: data stands in the cycle after the strobe only
    always_comb begin
        rdData_d = '0;
        if (regRdStb) begin
            unique case (regAddr)
                REG_CTRL: begin
                    rdData_d[CTRL_DEB_LSB +: DEB_W] = deb_q;
                    rdData_d[CTRL_GRP_LSB +: GRP_W] = grp_q;
                    rdData_d[CTRL_SYNC_BIT]         = sync_q;
                end
                REG_INPOL: begin
                    rdData_d[NUM_IN-1:0] = inPol_q;
                end
                REG_MODE: begin
                    rdData_d[NUM_IN-1:0] = mode_q;
                end
                REG_PPOL: begin
                    rdData_d[NUM_IN-1:0] = pPol_q;
                end
                REG_STATE: begin
                    rdData_d[NUM_IN-1:0] = inState;
                end
                REG_EVSTAT: begin
                    rdData_d = evStat_q;
                end
                REG_EVMASK: begin
                    rdData_d = evMask_q;
                end
                default: begin
                    rdData_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // a mask write in the same cycle may legally drop the interrupt
    sequence sPulse0Unmasked;
        pulseEvent[0] && evMask_q[EV_PLS_LSB] && !(regWrStb && regAddr == REG_EVMASK);
    endsequence

    sequence sSyncArmed;
        pulseEvent[0] && sync_q;
    endsequence

    AST_DEB_RANGE: assert property (
        deb_q >= DEB_MIN && deb_q <= DEB_MAX)
        else $error("debounce time out of range");

    AST_DEB_WRITE: assert property (
        regWrStb && regAddr == REG_CTRL
        |=> deb_q == clampDeb(DW'(DEB_W'($past(regWrData)))))
        else $error("debounce write not applied");

    AST_PULSE_STICKY: assert property (
        pulseEvent[0] |=> evStat_q[EV_PLS_LSB])
        else $error("pulse event not latched");

    AST_PULSE_IRQ: assert property (
        sPulse0Unmasked |=> irq)
        else $error("unmasked event gave no interrupt");

    AST_DEMAND_SYNC: assert property (
        sSyncArmed |=> demandSync ##1 !demandSync)
        else $error("demand sync not a single pulse");

    AST_SYNC_OFF: assert property (
        demandSync |-> $past(pulseEvent[0]) && $past(sync_q))
        else $error("demand sync without cause");

    AST_CHANGE_LEVEL: assert property (
        stateChange[0] && $stable(inPol_q) |-> inState[0] != $past(inState[0]))
        else $error("state change without level change");

    AST_OPT_OFF: assert property (
        !chanEn[NUM_IN-1] |=> !pulseEvent[NUM_IN-1] && !stateChange[NUM_IN-1])
        else $error("disabled input raised an event");

    AST_EVENT_PULSE: assert property (
        pulseEvent[0] |=> !pulseEvent[0])
        else $error("event longer than one cycle");

    AST_RD_STATE: assert property (
        regRdStb && regAddr == REG_STATE
        |=> regRdData[NUM_IN-1:0] == $past(inState))
        else $error("state read mismatch");
endmodule
`default_nettype wire

/* File: verif/dic_contacts.sv */
`default_nettype none
module dic_contacts (
    input  wire logic                       core_clk,
    input  wire logic [dic_pkg::NUM_IN-1:0] level,
    input  wire logic [dic_pkg::NUM_IN-1:0] chatter,
    output logic      [dic_pkg::NUM_IN-1:0] diRaw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tgl = 1'b0;
    // a bouncing contact flips every cycle, so it never stays still across a whole tick
    always @(posedge core_clk) begin
        tgl <= ~tgl;
    end
    assign diRaw = level ^ (chatter & {dic_pkg::NUM_IN{tgl}});
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dic_pkg::*;
    localparam int unsigned       TC    = 10;
    localparam int                LIMIT = 20000;
    localparam logic [NUM_IN-1:0] ALL   = 14'h3FFF;
    logic              core_clk, rst_n, regWrStb, regRdStb, demandSync, irq;
    logic [NUM_IN-1:0] level, chatter, diRaw, inState, stateChange, pulseEvent;
    logic [AW-1:0]     regAddr;
    logic [DW-1:0]     regWrData, regRdData, rd;
    int                mismatches = 0;
    int                n_compared = 0;
    int                cycles     = 0;
    int                nSync      = 0;
    logic              syncOn     = 1'b1;
    int                nChg [NUM_IN] = '{default: 0};
    int                nPls [NUM_IN] = '{default: 0};

    dic_top #(.TickCycles(TC)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .diRaw(diRaw), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .inState(inState), .stateChange(stateChange),
        .pulseEvent(pulseEvent), .demandSync(demandSync), .irq(irq));
    dic_contacts contacts (.core_clk(core_clk), .level(level), .chatter(chatter), .diRaw(diRaw));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // event counters; a pulse longer than one cycle shows up as an extra count
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        nSync <= nSync + int'(demandSync === 1'b1);
        for (int i = 0; i < NUM_IN; i++) begin
            nChg[i] <= nChg[i] + int'(stateChange[i] === 1'b1);
            nPls[i] <= nPls[i] + int'(pulseEvent[i] === 1'b1);
        end
        if (cycles == LIMIT) begin
            mismatches++;
            $display("unexpected at %0t: run hung", $time);
            print_verdict();
        end
    end

    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regWrStb <= 1'b0;
    endtask

    task automatic rdReg(input logic [AW-1:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        @(posedge core_clk);
        rd = regRdData;
    endtask

    function automatic logic [NUM_IN-1:0] expPulse(input logic [NUM_IN-1:0] md, pp, nl, chg);
        // single-edge: only the edge selected by pulse polarity; transition: every edge
        return chg & (md | (nl ^ pp));
    endfunction

    task automatic round(input logic [NUM_IN-1:0] ip, md, pp, flip, ch, en);
        logic [NUM_IN-1:0] old, nl, ePls;
        logic [DW-1:0]     exp, mk;
        int                c0 [NUM_IN];
        int                p0 [NUM_IN];
        int                s0;
        wr(REG_INPOL, DW'(ip));
        wr(REG_MODE, DW'(md));
        wr(REG_PPOL, DW'(pp));
        wr(REG_EVSTAT, 32'hFFFFFFFF);
        c0 = nChg;
        p0 = nPls;
        s0 = nSync;
        old = level;
        nl = level ^ flip;
        level <= nl;
        chatter <= ch;
        cyc(8);
        chk(DW'(inState), DW'((old & en) ^ ip), "early state");
        chatter <= '0;
        cyc(40);
        ePls = expPulse(md, pp, nl, flip & en);
        chk(DW'(inState), DW'((nl & en) ^ ip), "state");
        rdReg(REG_STATE);
        chk(rd, DW'((nl & en) ^ ip), "state read");
        for (int i = 0; i < NUM_IN; i++) begin
            chk(DW'(nChg[i] - c0[i]), DW'(flip[i] & en[i]), "change count");
            chk(DW'(nPls[i] - p0[i]), DW'(ePls[i]), "pulse count");
        end
        chk(DW'(nSync - s0), DW'(ePls[0] & syncOn), "sync count");
        exp = {2'b00, ePls, 2'b00, flip & en};
        rdReg(REG_EVSTAT);
        chk(rd, exp, "status");
        wr(REG_EVMASK, 32'h00000000);
        #1 chk(DW'(irq), 32'h0, "masked irq");
        mk = $urandom;
        wr(REG_EVMASK, mk);
        #1 chk(DW'(irq), DW'(|(exp & mk)), "irq");
        wr(REG_EVSTAT, exp);
        #1 chk(DW'(irq), 32'h0, "irq after clear");
        $display("round done");
    endtask

    initial begin
        rst_n = 1'b0;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        regAddr = '0;
        regWrData = '0;
        level = '0;
        chatter = '0;
        void'($urandom(77));
        cyc(10);
        rst_n <= 1'b1;
        rdReg(REG_CTRL);
        chk(rd, 32'h0000000A, "debounce default");
        rdReg(REG_EVSTAT);
        chk(rd, 32'h00000000, "status at reset");
        rdReg(8'h1C);
        chk(rd, 32'h00000000, "unmapped read");
        wr(REG_CTRL, 32'h00000000);
        rdReg(REG_CTRL);
        chk(rd, 32'h00000001, "debounce low clamp");
        wr(REG_CTRL, 32'h0000007F);
        rdReg(REG_CTRL);
        chk(rd, 32'h00000064, "debounce high clamp");
        $display("register test done");
        wr(REG_CTRL, 32'h00001302);
        round('0, '0, '0, ALL, '0, ALL);
        round('0, '0, '0, ALL, '0, ALL);
        round('0, '0, ALL, ALL, '0, ALL);
        round(ALL, ALL, 14'h2AAA, ALL, 14'h00F0, ALL);
        round(ALL, ALL, 14'h1555, ALL, '0, ALL);
        for (int r = 0; r < 6; r++) begin
            round(NUM_IN'($urandom), NUM_IN'($urandom), NUM_IN'($urandom),
                  NUM_IN'($urandom), NUM_IN'($urandom & $urandom), ALL);
        end
        wr(REG_CTRL, 32'h00000302);
        syncOn = 1'b0;
        round(NUM_IN'($urandom), NUM_IN'($urandom), NUM_IN'($urandom), ALL, '0, ALL);
        wr(REG_CTRL, 32'h00001002);
        syncOn = 1'b1;
        round(NUM_IN'($urandom), '0, '0, ALL, '0, 14'h0003);
        print_verdict();
    end
endmodule
`default_nettype wire
